// ==== core/alu_exec_pkg.sv ====
// Shared constants and types for the execute unit and its AHB-Lite slave
package alu_exec_pkg;
  // ==========================================================
  // Register word indices (haddr[5:2])
  localparam logic [3:0] IDX_CMD    = 4'h0;  // 0x00 command, write launches
  localparam logic [3:0] IDX_OPND   = 4'h1;  // 0x04 operand bytes
  localparam logic [3:0] IDX_FLAGS  = 4'h2;  // 0x08 flag_register
  localparam logic [3:0] IDX_PC     = 4'h3;  // 0x0c program counter
  localparam logic [3:0] IDX_ZPTR   = 4'h4;  // 0x10 Z pointer
  localparam logic [3:0] IDX_STACK  = 4'h5;  // 0x14 stack top word
  localparam logic [3:0] IDX_OFS    = 4'h6;  // 0x18 signed jump offset
  localparam logic [3:0] IDX_RESULT = 4'h7;  // 0x1c result, read only
  localparam logic [3:0] IDX_STATUS = 4'h8;  // 0x20 status, read only
  // ==========================================================
  // Flag bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;   // Flags after reset
  localparam int PC_W_DEF = 22;               // Program counter width
  // ==========================================================
  // Operations
  typedef enum logic [5:0] {
    OP_ADD = 6'h00, OP_ADC = 6'h01, OP_SUB = 6'h02, OP_SBC = 6'h03,
    OP_PADD = 6'h04, OP_PSUB = 6'h05, OP_AND = 6'h06, OP_OR = 6'h07,
    OP_XOR = 6'h08, OP_TST = 6'h09, OP_SETB = 6'h0a, OP_CLRB = 6'h0b,
    OP_CMP = 6'h0c, OP_CMPC = 6'h0d, OP_MUU = 6'h0e, OP_MSS = 6'h0f,
    OP_MSU = 6'h10, OP_FUU = 6'h11, OP_FSS = 6'h12, OP_FSU = 6'h13,
    OP_RGOTO = 6'h14, OP_PGOTO = 6'h15, OP_PC_REL_INVOKE = 6'h16, OP_PCALL = 6'h17,
    OP_RET = 6'h18, OP_IRQ_HANDLER_EXIT = 6'h19, OP_EQSKIP = 6'h1a, OP_RB0SKIP = 6'h1b,
    OP_RB1SKIP = 6'h1c, OP_IO0SKIP = 6'h1d, OP_IO1SKIP = 6'h1e,
    OP_FSETBR = 6'h1f, OP_FCLRBR = 6'h20
  } op_t;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} state_t;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [21:0] pad;       // Ignored
    logic        twoWord;   // Skipped instruction is two words
    logic [2:0]  bitSel;    // Bit / flag select
    op_t         op;        // Operation
  } cmd_t;
  typedef struct packed {
    logic [7:0] io;         // Low I/O register value
    logic [7:0] src;        // source_reg or immediate
    logic [7:0] hi;         // Destination + 1
    logic [7:0] dst;        // Destination
  } opnd_t;
endpackage : alu_exec_pkg

// ==== core/alu_exec.sv ====
// Execute stage: ALU, multiplier and flow control behind an AHB-Lite slave
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// RL1: subtract reg/imm, optional borrow, six flags, 1 cycle
// RL2: add, add-with-carry, six flags, 1 cycle
// RL3: pair add/sub immediate, no H, 2 cycles
// RL4: AND/OR/XOR set Z,N,V,S; keep C,H
// RL5: test sets flags, register kept, 1 cycle
// RL6: set-bits ORs mask, four flags, 1 cycle
// RL7: clear-bits ANDs inverted mask, 1 cycle
// RL8: multiply uu/ss/su into r1:r0, Z,C, 2 cycles
// RL9: fractional multiply shifts product left, 2 cycles
// RL10: relative call PC+k+1, 2 or 3 cycles
// RL11: pointer goto loads Z, upper PC zero
// RL12: pointer call from Z, 2 or 3 cycles
// RL13: equal skip advances 2/3, no flags
// RL14: compare immediate updates six flags only
// RL15: register-bit skip on clear or set
// RL16: I/O-bit skip on set or clear, no flags
// RL17: flag branch PC+k+1, 1 or 2 cycles
// RL18: signed branches test N xor V
// RL19: unsigned branches test carry
// RL20: interrupt branches test I flag
// RL21: half-carry branch tests H flag
// RL22: overflow branches test V, flags kept
// RL23: return pops PC; irq return sets I
module alu_exec
  import alu_exec_pkg::*;
#(
  parameter int PC_W = PC_W_DEF            // Program counter width
) (
  input  wire logic        mclk,       // Core clock, 10 MHz
  input  wire logic        sys_rst,    // Synchronous reset, high
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Byte address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write when high
  input  wire logic [2:0]  hsize,      // Word only
  input  wire logic [31:0] hwdata,     // Write data
  input  wire logic        hready,     // Bus ready
  output logic             hreadyout,  // Always ready
  output logic             hresp,      // Always OKAY
  output logic      [31:0] hrdata,     // Read data
  output logic             busy        // Operation in progress
);
  import alu_exec_pkg::*;

  // ==========================================================
  // Bus slave
  logic            wrPend_reg;   // Write data phase pending
  logic [3:0]      wrIdx_reg;    // Index of pending write
  logic            addrOk;       // Valid address phase
  logic            launch;       // Command accepted this cycle
  logic            launchQ;      // First busy cycle
  cmd_t            cmdReg;       // Latched command
  opnd_t           opndReg;      // Operand bytes
  logic [7:0]      flagsReg;     // flag_register
  logic [PC_W-1:0] pcReg;        // Program counter
  logic [15:0]     zReg;         // Z pointer
  logic [PC_W-1:0] stackReg;     // Top of stack
  logic [11:0]     ofsReg;       // Jump offset
  logic [15:0]     resReg;       // Result word
  logic            resWrReg;     // Result is written back
  logic            takenReg;     // Branch or skip taken
  logic [2:0]      cycReg;       // Cycles of last op
  logic [2:0]      cntReg;       // Cycles remaining
  state_t          stateReg;     // Sequencer state
  cmd_t            cmdIn;        // Command on the bus

  assign addrOk    = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign cmdIn     = cmd_t'(hwdata);
  // Command writes during a run are dropped; software polls busy
  assign launch    = wrPend_reg && (wrIdx_reg == IDX_CMD) && (stateReg == ST_IDLE);
  assign busy      = (stateReg == ST_RUN);

  // Address phase capture, zero wait states
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg  <= 4'h0;
    end else begin
      wrPend_reg <= addrOk & hwrite;
      wrIdx_reg  <= haddr[5:2];
    end
  end

  // Read data registered in the address phase; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hrdata <= 32'h0;
    end else if (addrOk && !hwrite) begin
      unique case (haddr[5:2])
        IDX_CMD:    hrdata <= cmdReg;
        IDX_OPND:   hrdata <= opndReg;
        IDX_FLAGS:  hrdata <= {24'h0, flagsReg};
        IDX_PC:     hrdata <= 32'(pcReg);
        IDX_ZPTR:   hrdata <= {16'h0, zReg};
        IDX_STACK:  hrdata <= 32'(stackReg);
        IDX_OFS:    hrdata <= {20'h0, ofsReg};
        IDX_RESULT: hrdata <= {15'h0, resWrReg, resReg};
        IDX_STATUS: hrdata <= {27'h0, takenReg, cycReg, busy};
        default:    hrdata <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Operation datapath
  logic [7:0]      a, b, r8;     // Operands and byte result
  logic [8:0]      s9;           // Byte sum or difference
  logic [16:0]     s17;          // Pair sum or difference
  logic [15:0]     ea, eb, prod; // Extended operands, product
  logic            cin;          // Carry in
  logic            isSub;        // Subtract family
  logic            cond;         // Tested condition
  logic [PC_W-1:0] kShort;       // Branch offset
  logic [PC_W-1:0] kLong;        // Relative goto offset
  logic [PC_W-1:0] pcSkip;       // Skip target
  logic [7:0]      fN;           // Next flags
  logic [PC_W-1:0] pcN;          // Next PC
  logic [PC_W-1:0] stN;          // Next stack top
  logic [15:0]     resN;         // Next result
  logic            wrN;          // Next write-back flag
  logic            tkN;          // Next taken flag
  logic [2:0]      cycN;         // Cycle count
  logic [2:0]      callCyc;      // Call length by PC width
  logic [2:0]      retCyc;       // Return length by PC width

  assign a       = opndReg.dst;
  assign b       = opndReg.src;
  assign callCyc = (PC_W > 16) ? 3'h3 : 3'h2;   // [RL10] [RL12]
  assign retCyc  = (PC_W > 16) ? 3'h5 : 3'h4;   // [RL23]
  assign kShort  = PC_W'({{(PC_W - 7){ofsReg[6]}}, ofsReg[6:0]});
  assign kLong   = PC_W'({{(PC_W - 12){ofsReg[11]}}, ofsReg});
  // Skip advances past a one- or two-word instruction
  assign pcSkip  = pcReg + (cmdIn.twoWord ? PC_W'(3) : PC_W'(2));

  // Next state of flags, PC, stack and result for the command on the bus
  always_comb begin
    fN    = flagsReg;
    pcN   = pcReg + PC_W'(1);
    stN   = stackReg;
    resN  = {8'h0, a};
    wrN   = 1'b0;
    tkN   = 1'b0;
    cycN  = 3'h1;
    cin   = 1'b0;
    isSub = 1'b0;
    r8    = 8'h0;
    s9    = 9'h0;
    s17   = 17'h0;
    ea    = 16'h0;
    eb    = 16'h0;
    prod  = 16'h0;
    cond  = 1'b0;
    unique case (cmdIn.op)
      // Byte add and subtract, including compares
      OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP, OP_CMPC: begin
        cin   = (cmdIn.op == OP_ADC || cmdIn.op == OP_SBC || cmdIn.op == OP_CMPC)
                && flagsReg[FL_C];
        isSub = !(cmdIn.op == OP_ADD || cmdIn.op == OP_ADC);
        if (isSub) begin
          s9 = {1'b0, a} - {1'b0, b} - {8'h0, cin};                  // [RL1] [RL14]
          r8 = s9[7:0];
          fN[FL_H] = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
          fN[FL_V] = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
        end else begin
          s9 = {1'b0, a} + {1'b0, b} + {8'h0, cin};                  // [RL2]
          r8 = s9[7:0];
          fN[FL_H] = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
          fN[FL_V] = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
        end
        fN[FL_C] = s9[8];
        fN[FL_N] = r8[7];
        fN[FL_S] = r8[7] ^ fN[FL_V];
        // Borrow forms keep Z sticky across multi-byte chains
        fN[FL_Z] = (r8 == 8'h0) & ((cmdIn.op == OP_SBC || cmdIn.op == OP_CMPC)
                   ? flagsReg[FL_Z] : 1'b1);
        resN = {8'h0, r8};
        wrN  = !(cmdIn.op == OP_CMP || cmdIn.op == OP_CMPC);         // [RL14]
      end
      // Word immediate on the register pair; H untouched
      OP_PADD, OP_PSUB: begin
        s17 = (cmdIn.op == OP_PSUB) ? {1'b0, opndReg.hi, a} - {11'h0, b[5:0]}
                                    : {1'b0, opndReg.hi, a} + {11'h0, b[5:0]}; // [RL3]
        fN[FL_C] = s17[16];
        fN[FL_Z] = (s17[15:0] == 16'h0);
        fN[FL_N] = s17[15];
        fN[FL_V] = (cmdIn.op == OP_PSUB) ? (opndReg.hi[7] & ~s17[15])
                                         : (~opndReg.hi[7] & s17[15]);
        fN[FL_S] = s17[15] ^ fN[FL_V];
        resN = s17[15:0];
        wrN  = 1'b1;
        cycN = 3'h2;
      end
      // Logic group: V cleared, C and H kept
      OP_AND, OP_OR, OP_XOR, OP_TST, OP_SETB, OP_CLRB: begin
        unique case (cmdIn.op)
          OP_AND:  r8 = a & b;                                       // [RL4]
          OP_XOR:  r8 = a ^ b;
          OP_TST:  r8 = a & a;                                       // [RL5]
          OP_CLRB: r8 = a & ~b;                                      // [RL7]
          default: r8 = a | b;                                       // [RL6]
        endcase
        fN[FL_Z] = (r8 == 8'h0);
        fN[FL_N] = r8[7];
        fN[FL_V] = 1'b0;
        fN[FL_S] = r8[7];
        resN = {8'h0, r8};
        wrN  = (cmdIn.op != OP_TST);                                 // [RL5]
      end
      // Multiplier; signed operands sign-extended, unsigned ones zero-extended, product kept mod 2^16
      OP_MUU, OP_MSS, OP_MSU, OP_FUU, OP_FSS, OP_FSU: begin
        ea = (cmdIn.op inside {OP_MSS, OP_MSU, OP_FSS, OP_FSU})
             ? {{8{a[7]}}, a} : {8'h0, a};
        eb = (cmdIn.op inside {OP_MSS, OP_FSS}) ? {{8{b[7]}}, b} : {8'h0, b};
        prod = ea * eb;                                              // [RL8]
        fN[FL_C] = prod[15];
        resN = (cmdIn.op inside {OP_FUU, OP_FSS, OP_FSU})
               ? {prod[14:0], 1'b0} : prod;                          // [RL9]
        fN[FL_Z] = (resN == 16'h0);
        wrN  = 1'b1;
        cycN = 3'h2;
      end
      // Jumps and calls
      OP_RGOTO: begin
        pcN  = pcReg + kLong + PC_W'(1);
        cycN = 3'h2;
      end
      OP_PGOTO: begin
        pcN  = PC_W'(zReg);                                          // [RL11]
        cycN = 3'h2;
      end
      OP_PC_REL_INVOKE: begin
        stN  = pcReg + PC_W'(1);
        pcN  = pcReg + kLong + PC_W'(1);                             // [RL10]
        cycN = callCyc;
      end
      OP_PCALL: begin
        stN  = pcReg + PC_W'(1);
        pcN  = PC_W'(zReg);                                          // [RL12]
        cycN = callCyc;
      end
      OP_RET, OP_IRQ_HANDLER_EXIT: begin
        pcN  = stackReg;                                             // [RL23]
        if (cmdIn.op == OP_IRQ_HANDLER_EXIT) fN[FL_I] = 1'b1;
        cycN = retCyc;
      end
      // Skips; flags never change
      OP_EQSKIP, OP_RB0SKIP, OP_RB1SKIP, OP_IO0SKIP, OP_IO1SKIP: begin
        unique case (cmdIn.op)
          OP_EQSKIP:  cond = (a == b);                               // [RL13]
          OP_RB0SKIP: cond = !b[cmdIn.bitSel];                       // [RL15]
          OP_RB1SKIP: cond = b[cmdIn.bitSel];
          OP_IO0SKIP: cond = !opndReg.io[cmdIn.bitSel];              // [RL16]
          default:    cond = opndReg.io[cmdIn.bitSel];
        endcase
        tkN = cond;
        if (cond) begin
          pcN  = pcSkip;
          cycN = cmdIn.twoWord ? 3'h3 : 3'h2;
        end
      end
      // Flag branches; named forms pick a bit: S for signed, C unsigned,
      // I for interrupt state, H half carry, V overflow
      default: begin
        cond = flagsReg[cmdIn.bitSel] ^ (cmdIn.op == OP_FCLRBR);     // [RL17] [RL18]
        tkN  = cond;                                                 // [RL19] [RL20]
        if (cond) begin                                              // [RL21] [RL22]
          pcN  = pcReg + kShort + PC_W'(1);
          cycN = 3'h2;
        end
      end
    endcase
  end

  // ==========================================================
  // Software-writable state; a launch commits results at the same edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmdReg   <= cmd_t'(32'h0);
      opndReg  <= opnd_t'(32'h0);
      flagsReg <= FLAGS_RST;
      pcReg    <= '0;
      zReg     <= 16'h0;
      stackReg <= '0;
      ofsReg   <= 12'h0;
    end else if (launch) begin
      cmdReg   <= cmdIn;
      flagsReg <= fN;
      pcReg    <= pcN;
      stackReg <= stN;
      if (wrN) opndReg <= opnd_t'({opndReg.io, opndReg.src, resN});
    end else if (wrPend_reg) begin
      unique case (wrIdx_reg)
        IDX_OPND:  opndReg  <= opnd_t'(hwdata);
        IDX_FLAGS: flagsReg <= hwdata[7:0];
        IDX_PC:    pcReg    <= hwdata[PC_W-1:0];
        IDX_ZPTR:  zReg     <= hwdata[15:0];
        IDX_STACK: stackReg <= hwdata[PC_W-1:0];
        IDX_OFS:   ofsReg   <= hwdata[11:0];
        default:   ;
      endcase
    end
  end

  // Result and status of the last operation
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      resReg   <= 16'h0;
      resWrReg <= 1'b0;
      takenReg <= 1'b0;
      cycReg   <= 3'h0;
    end else if (launch) begin
      resReg   <= resN;
      resWrReg <= wrN;
      takenReg <= tkN;
      cycReg   <= cycN;
    end
  end

  // ==========================================================
  // Cycle sequencer: busy stands for exactly the operation's length
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stateReg <= ST_IDLE;
      cntReg   <= 3'h0;
      launchQ  <= 1'b0;
    end else begin
      launchQ <= launch;
      unique case (stateReg)
        ST_IDLE: if (launch) begin
          stateReg <= ST_RUN;
          cntReg   <= cycN;
        end
        ST_RUN: begin
          cntReg <= cntReg - 3'h1;
          if (cntReg == 3'h1) stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  sequence two_busy;
    busy ##1 busy ##1 !busy;
  endsequence

  a_sub_one: assert property (@(posedge mclk) disable iff (sys_rst) // [RL1]
    launchQ && cmdReg.op == OP_SUB |-> busy ##1 !busy)
    else $error("subtract not one cycle");
  a_add_carry: assert property (@(posedge mclk) disable iff (sys_rst) // [RL2]
    launchQ && cmdReg.op == OP_ADD |->
    flagsReg[FL_C] == ((9'($past(a)) + 9'($past(b))) > 9'h0ff))
    else $error("add carry wrong");
  a_pair_len: assert property (@(posedge mclk) disable iff (sys_rst) // [RL3]
    launchQ && cmdReg.op inside {OP_PADD, OP_PSUB} |->
    flagsReg[FL_H] == $past(flagsReg[FL_H]) ##0 two_busy)
    else $error("pair op wrong");
  a_logic_keep: assert property (@(posedge mclk) disable iff (sys_rst) // [RL4]
    launchQ && cmdReg.op inside {OP_AND, OP_OR, OP_XOR} |->
    flagsReg[FL_C] == $past(flagsReg[FL_C]) && !flagsReg[FL_V])
    else $error("logic flags wrong");
  a_test_keep: assert property (@(posedge mclk) disable iff (sys_rst) // [RL5]
    launchQ && cmdReg.op == OP_TST |-> opndReg == $past(opndReg))
    else $error("test changed register");
  a_mul_len: assert property (@(posedge mclk) disable iff (sys_rst) // [RL8]
    launchQ && cmdReg.op inside {OP_MUU, OP_MSS, OP_MSU} |->
    two_busy and (flagsReg[FL_Z] == (resReg == 16'h0)))
    else $error("multiply wrong");
  a_frac_lsb: assert property (@(posedge mclk) disable iff (sys_rst) // [RL9]
    launchQ && cmdReg.op inside {OP_FUU, OP_FSS, OP_FSU} |-> !resReg[0])
    else $error("fraction not shifted");
  a_ptr_goto: assert property (@(posedge mclk) disable iff (sys_rst) // [RL11]
    launchQ && cmdReg.op == OP_PGOTO |-> pcReg == PC_W'($past(zReg)))
    else $error("pointer goto target wrong");
  a_skip_flags: assert property (@(posedge mclk) disable iff (sys_rst) // [RL13]
    launchQ && cmdReg.op inside {OP_EQSKIP, OP_IO0SKIP, OP_IO1SKIP} |->
    flagsReg == $past(flagsReg))
    else $error("skip altered flags");
  a_cmp_keep: assert property (@(posedge mclk) disable iff (sys_rst) // [RL14]
    launchQ && cmdReg.op == OP_CMP |-> !resWrReg && opndReg == $past(opndReg))
    else $error("compare wrote register");
  a_branch_len: assert property (@(posedge mclk) disable iff (sys_rst) // [RL17]
    launchQ && cmdReg.op inside {OP_FSETBR, OP_FCLRBR} && takenReg |->
    busy ##1 busy ##1 !busy)
    else $error("taken branch not two cycles");
  a_irq_handler_exit_irq: assert property (@(posedge mclk) disable iff (sys_rst) // [RL23]
    launchQ && cmdReg.op == OP_IRQ_HANDLER_EXIT |-> flagsReg[FL_I] && pcReg == $past(stackReg))
    else $error("irq return wrong");
endmodule : alu_exec

// ==== test/cpu_alu_and_branch_exec_tb.sv ====
// Self-checking bench for the execute unit, driven over its AHB-Lite slave
`timescale 1ns/1ps
module cpu_alu_and_branch_exec_tb;
  import alu_exec_pkg::*;
  // ==========================================================
  // Bus, clock and stimulus state
  logic        mclk    = 1'b0;      // Core clock, 100 ns period
  logic        sys_rst = 1'b1;      // Held for 12 cycles
  logic        hsel    = 1'b0;      // Slave select
  logic [31:0] haddr   = 32'h0;     // Byte address
  logic [1:0]  htrans  = 2'b00;     // IDLE or NONSEQ
  logic        hwrite  = 1'b0;      // Direction
  logic [2:0]  hsize   = 3'b010;    // Whole words only
  logic [31:0] hwdata  = 32'h0;     // Write data
  wire logic   hready;              // Single slave: its own ready
  logic        hreadyout, hresp, busy;
  logic [31:0] hrdata, rd, expOpnd;
  logic [7:0]  d, s, hi, io, flagsIn, expFlags;  // Operand bytes and flags
  logic [21:0] pcIn, stackIn, expPc, expStack;
  logic [15:0] zIn;                 // Pointer value
  logic [11:0] ofsIn;               // Signed jump offset
  logic [2:0]  bitSel, expCycles;
  logic        twoWord, expTaken;
  op_t         op;
  int          errTotal = 0;
  int          testsRun = 0;
  assign hready = hreadyout;
  always #50 mclk = ~mclk;
  alu_exec dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .busy(busy));
  // ==========================================================
  // Reporting
  task automatic close_out();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    testsRun++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s got %h exp %h op %0d", $time, msg, got, exp, op);
      errTotal++;
    end
  endtask : chk
  // ==========================================================
  // One single AHB-Lite transfer; called just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 20);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 40);
    rd = hrdata;            // Read data taken at the closing edge
    chk({31'h0, hresp}, 32'h0, "hresp not OKAY");
    if (hready !== 1'b1) begin
      chk(32'h0, 32'h1, "bus wait ran out");
      close_out();
    end
  endtask : bus
  task automatic rdchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string msg);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e, msg);
  endtask : rdchk
  // ==========================================================
  // Expected outcome of one operation, worked out from the operands
  task automatic predict();
    logic [16:0] w;
    logic [15:0] p;
    logic        v, h, cin, cond;
    int          a, b;
    logic [21:0] k12, k7;
    k12 = {{10{ofsIn[11]}}, ofsIn};
    k7 = {{15{ofsIn[6]}}, ofsIn[6:0]};
    expOpnd = {io, s, hi, d};
    expFlags = flagsIn;
    expPc = pcIn + 22'h1;   // Plain operations step to the next word
    expStack = stackIn;
    expCycles = 3'h1;
    expTaken = 1'b0;
    v = 1'b0;
    h = 1'b0;
    w = 17'h0;
    cin = (op inside {OP_ADC, OP_SBC, OP_CMPC}) ? flagsIn[FL_C] : 1'b0;
    case (op)
      OP_ADD, OP_ADC: begin
        w = d + s + cin;
        h = ({1'b0, d[3:0]} + s[3:0] + cin) > 5'h0f;
        v = (d[7] == s[7]) && (w[7] != d[7]);
      end
      OP_SUB, OP_SBC, OP_CMP, OP_CMPC: begin
        w = d - s - cin;    // Borrow lands in bit 8
        h = {1'b0, d[3:0]} < ({1'b0, s[3:0]} + cin);
        v = (d[7] != s[7]) && (w[7] != d[7]);
      end
      OP_AND:        w = {9'h0, d & s};
      OP_TST:        w = {9'h0, d};
      OP_OR, OP_SETB: w = {9'h0, d | s};
      OP_XOR:        w = {9'h0, d ^ s};
      OP_CLRB:       w = {9'h0, d & ~s};
      OP_PADD, OP_PSUB: begin
        w = (op == OP_PADD) ? {hi, d} + s[5:0] : {hi, d} - s[5:0];
        v = (op == OP_PADD) ? (~hi[7] & w[15]) : (hi[7] & ~w[15]);
        expFlags[FL_C] = w[16];
        expFlags[FL_Z] = (w[15:0] == 16'h0);
        expFlags[FL_N] = w[15];
        expFlags[FL_V] = v;
        expFlags[FL_S] = w[15] ^ v;
        expOpnd[15:0] = w[15:0];
        expCycles = 3'h2;
      end
      OP_MUU, OP_MSS, OP_MSU, OP_FUU, OP_FSS, OP_FSU: begin
        a = (op inside {OP_MSS, OP_MSU, OP_FSS, OP_FSU}) ? int'($signed(d)) : int'(d);
        b = (op inside {OP_MSS, OP_FSS}) ? int'($signed(s)) : int'(s);
        p = 16'(a * b);
        expFlags[FL_C] = p[15];
        if (op inside {OP_FUU, OP_FSS, OP_FSU}) p = p << 1;
        expFlags[FL_Z] = (p == 16'h0);
        expOpnd[15:0] = p;
        expCycles = 3'h2;
      end
      OP_RGOTO, OP_PC_REL_INVOKE: expPc = pcIn + k12 + 22'h1;
      OP_PGOTO, OP_PCALL: expPc = {6'h0, zIn};
      OP_RET, OP_IRQ_HANDLER_EXIT: expPc = stackIn;
      OP_FSETBR, OP_FCLRBR: begin
        expTaken = (flagsIn[bitSel] == (op == OP_FSETBR));
        if (expTaken) expPc = pcIn + k7 + 22'h1;
        expCycles = expTaken ? 3'h2 : 3'h1;
      end
      default: begin        // The four skips and the equal skip
        cond = (op == OP_EQSKIP) ? (d == s) : (op == OP_RB0SKIP) ? !s[bitSel] :
               (op == OP_RB1SKIP) ? s[bitSel] : (op == OP_IO0SKIP) ? !io[bitSel] : io[bitSel];
        expTaken = cond;
        if (cond) expPc = pcIn + 22'h2 + twoWord;
        expCycles = cond ? 3'h2 + twoWord : 3'h1;
      end
    endcase
    if (op <= OP_CMPC && !(op inside {OP_PADD, OP_PSUB})) begin
      expFlags[FL_Z] = (w[7:0] == 8'h0) && (!(op inside {OP_SBC, OP_CMPC}) || flagsIn[FL_Z]);
      expFlags[FL_N] = w[7];
      expFlags[FL_V] = v;
      expFlags[FL_S] = w[7] ^ v;
      if (!(op inside {OP_AND, OP_OR, OP_XOR, OP_TST, OP_SETB, OP_CLRB})) begin
        expFlags[FL_C] = w[8];
        expFlags[FL_H] = h;
      end
      if (!(op inside {OP_CMP, OP_CMPC, OP_TST})) expOpnd[15:0] = {8'h0, w[7:0]};
    end
    if (op inside {OP_PC_REL_INVOKE, OP_PCALL}) expStack = pcIn + 22'h1;
    if (op inside {OP_RGOTO, OP_PGOTO}) expCycles = 3'h2;
    if (op inside {OP_PC_REL_INVOKE, OP_PCALL}) expCycles = 3'h3;
    if (op inside {OP_RET, OP_IRQ_HANDLER_EXIT}) expCycles = 3'h5;
    if (op == OP_IRQ_HANDLER_EXIT) expFlags[FL_I] = 1'b1;
  endtask : predict
  // ==========================================================
  // Fresh random operands, then one complete launch and check
  task automatic roll();
    {d, s, hi, io} = $urandom;
    flagsIn = 8'($urandom);
    pcIn = 22'($urandom);
    stackIn = 22'($urandom);
    zIn = 16'($urandom);
    ofsIn = 12'($urandom);
    bitSel = 3'($urandom);
    twoWord = 1'($urandom);
    if ($urandom_range(0, 1) == 1) s = d;
  endtask : roll
  task automatic go();
    cmd_t c;
    int   n;
    c = '0;
    c.op = op;
    c.bitSel = bitSel;
    c.twoWord = twoWord;
    predict();
    bus(1'b1, 32'h08, {24'h0, flagsIn});
    bus(1'b1, 32'h0c, {10'h0, pcIn});
    bus(1'b1, 32'h10, {16'h0, zIn});
    bus(1'b1, 32'h14, {10'h0, stackIn});
    bus(1'b1, 32'h18, {20'h0, ofsIn});
    bus(1'b1, 32'h04, {io, s, hi, d});
    bus(1'b1, 32'h00, 32'(c));
    if (expCycles > 3'h2) bus(1'b1, 32'h00, 32'h0);  // Launch while busy must be dropped
    bus(1'b0, 32'h20, 32'h0);
    chk({31'h0, rd[0]}, 32'h1, "busy bit not set");
    n = 0;
    while (rd[0] !== 1'b0 && n < 20) begin bus(1'b0, 32'h20, 32'h0); n++; end
    if (rd[0] !== 1'b0) begin
      chk(32'h0, 32'h1, "busy never fell");
      close_out();
    end
    chk({31'h0, busy}, 32'h0, "busy pin");
    chk({28'h0, rd[4:1]}, {28'h0, expTaken, expCycles}, "timing");
    rdchk(32'h04, 32'hffffffff, expOpnd, "opnd");
    rdchk(32'h08, 32'hff, {24'h0, expFlags}, "flags");
    rdchk(32'h0c, 32'h3fffff, {10'h0, expPc}, "pc");
    rdchk(32'h14, 32'h3fffff, {10'h0, expStack}, "stack");
  endtask : go
  // ==========================================================
  // Main sequence: reset values, every code, corners, random mix
  initial begin
    void'($urandom(32'hb787bf2b));
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    rdchk(32'h0c, 32'hffffffff, 32'h0, "pc after reset");
    rdchk(32'h08, 32'hffffffff, 32'h0, "flags after reset");
    bus(1'b1, 32'h24, 32'hffffffff);
    rdchk(32'h24, 32'hffffffff, 32'h0, "unmapped");
    $display("test reset and map done");
    for (int i = 0; i <= 32; i++) begin
      for (int j = 0; j < 8; j++) begin
        op = op_t'(i);
        roll();
        bitSel = 3'(j);  // Every flag and bit position for each code
        go();
      end
    end
    $display("test code sweep done");
    for (int i = 0; i < 8; i++) begin
      roll();
      op = (i < 4) ? ((i % 2 == 1) ? OP_PSUB : OP_SUB) : ((i % 2 == 1) ? OP_FSS : OP_MSS);
      {d, s, hi} = {8'h80, (i < 4) ? 8'h01 : 8'h80, 8'h00};
      go();
    end
    $display("test corners done");
    repeat (150) begin
      op = op_t'($urandom_range(0, 32));
      roll();
      go();
    end
    $display("test random mix done");
    close_out();
  end
endmodule : cpu_alu_and_branch_exec_tb
